// ===== inc/dsar_pkg.sv
// Shared constants, states and carrier structs of the differential SAR sequencer
package dsar_pkg;

	localparam int DSAR_BITS = 16;
	localparam int DSAR_CLK_NS = 50;
	// Internal conversion clock period, one comparator decision per period
	localparam int DSAR_STEP_NS = 150;
	localparam int DSAR_STEP_CYC = (DSAR_STEP_NS + DSAR_CLK_NS - 1) / DSAR_CLK_NS;
	// Highest conversion rate the sequence is sized for
	localparam int DSAR_MAX_KSPS = 100;
	localparam int DSAR_FRAME_NS = 1000000 / DSAR_MAX_KSPS;

	localparam logic [15:0] DSAR_MSB_TRIAL = 16'h8000;
	localparam logic [15:0] DSAR_LSB_TRIAL = 16'h0001;
	localparam logic [15:0] DSAR_CODE_RESET = 16'h0000;
	localparam logic [3:0] DSAR_STEP_LAST = 4'(DSAR_STEP_CYC - 1);
	localparam logic [4:0] DSAR_FALL_OUT_EN = 5'h05;
	localparam logic [4:0] DSAR_FALL_LAST = 5'h15;
	localparam int DSAR_SIGN_POS = 15;

	typedef enum logic [2:0] {
		DSAR_ACQUIRE = 3'b000,
		DSAR_OPEN_GND = 3'b001,
		DSAR_TO_GND = 3'b010,
		DSAR_SEARCH = 3'b011,
		DSAR_FINISH = 3'b100
	} dsar_phase_e;

	typedef struct packed {
		logic [15:0] pos_sel;
		logic [15:0] neg_sel;
	} dsar_array_s;

	typedef struct packed {
		logic data;
		logic oe;
	} dsar_serial_s;

	typedef struct packed {
		logic cs_meta;
		logic cs_sync;
		logic cs_last;
		logic sck_meta;
		logic sck_sync;
		logic sck_last;
		logic cmp_meta;
		logic cmp_sync;
		dsar_phase_e phase;
		logic [15:0] code;
		logic [15:0] trial;
		logic [3:0] step;
		logic gnd_closed;
		logic arr_to_input;
		logic powered;
		logic done;
		dsar_array_s arr;
		logic [4:0] fall_cnt;
		dsar_serial_s sout;
	} dsar_state_s;

	localparam dsar_state_s DSAR_RESET = '{
		cs_meta: 1'b1, cs_sync: 1'b1, cs_last: 1'b1,
		sck_meta: 1'b1, sck_sync: 1'b1, sck_last: 1'b1,
		cmp_meta: 1'b0, cmp_sync: 1'b0,
		phase: DSAR_ACQUIRE,
		code: DSAR_CODE_RESET, trial: DSAR_CODE_RESET, step: 4'h0,
		gnd_closed: 1'b1, arr_to_input: 1'b1, powered: 1'b0, done: 1'b0,
		arr: '{pos_sel: 16'h0000, neg_sel: 16'h0000},
		fall_cnt: 5'h00,
		sout: '{data: 1'b0, oe: 1'b0}
	};

endpackage

// ===== rtl/dsar_seq.sv
// Conversion sequencer and serial readout of a 16-bit differential SAR converter
// What this block does
// - Start conversion on select fall after acquisition
// - Open ground switches, then arrays to ground
// - One select bit per element, both arrays
// - Binary search from MSB, comparator keeps bits
// - After search, back to acquisition, code formed
// - Fits 100 kSPS, powered down between conversions
// - Result read belongs to same conversion
// - Output is 16-bit two's complement
// - Overrange saturates at 7FFF
// - Underrange saturates at 8000
// - Output enabled low after fifth fall, MSB first
// - Shutdown right after conversion, no command
module dsar_seq
	import dsar_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic serial_shift_clock,
	input wire logic comp_above,
	output logic pos_input_ground_switch,
	output logic neg_input_ground_switch,
	output logic arrays_to_input,
	output dsar_array_s array_sel,
	output logic powered_up,
	output logic conv_done,
	output dsar_serial_s serial_out
);

	dsar_state_s s;
	dsar_state_s next_s;

	// Qualifiers derived from the synchronised pins
	logic cs_high;
	logic cs_fall;
	logic sck_fall;
	// Search step decode
	logic step_end;
	logic last_probe;
	logic keep_bit;
	logic [15:0] next_code;
	logic [15:0] next_trial;
	logic [15:0] probe;
	// Result formatting and readout decode
	logic [15:0] twos;
	logic count_open;
	logic [4:0] next_fall;
	logic at_enable;
	logic in_data;
	logic [3:0] bit_idx;
	logic result_bit;

	always_comb begin
		// Hold state; every decode signal gets a default
		next_s = s;
		cs_high = 1'b1;
		cs_fall = 1'b0;
		sck_fall = 1'b0;
		step_end = 1'b0;
		last_probe = 1'b0;
		keep_bit = 1'b0;
		next_code = s.code;
		next_trial = s.trial;
		probe = s.arr.pos_sel;
		twos = DSAR_CODE_RESET;
		count_open = 1'b0;
		next_fall = s.fall_cnt;
		at_enable = 1'b0;
		in_data = 1'b0;
		bit_idx = 4'h0;
		result_bit = 1'b0;
		next_s.done = 1'b0;

		// Two flip-flops on every pin before any logic reads it
		next_s.cs_meta = cs_n;
		next_s.cs_sync = s.cs_meta;
		next_s.cs_last = s.cs_sync;
		next_s.sck_meta = serial_shift_clock;
		next_s.sck_sync = s.sck_meta;
		next_s.sck_last = s.sck_sync;
		next_s.cmp_meta = comp_above;
		next_s.cmp_sync = s.cmp_meta;

		// Edges come from the second and third stages only
		cs_high = s.cs_sync;
		cs_fall = s.cs_last & ~s.cs_sync;
		sck_fall = s.sck_last & ~s.sck_sync;

		// Comparator is read on the last cycle of a step, after two syncs
		step_end = (s.step == DSAR_STEP_LAST);
		last_probe = (s.trial == DSAR_LSB_TRIAL);
		// Comparator high: input above trial level, bit stays
		keep_bit = step_end & s.cmp_sync;
		if (keep_bit) begin
			next_code = s.code | s.trial;
		end
		if (step_end) begin
			next_trial = s.trial >> 1;
		end
		// Kept bits plus the next trial bit form the next switch pattern
		probe = next_code | next_trial;

		// Phase sequence of one conversion
		unique case (s.phase)
			DSAR_ACQUIRE: begin
				// Arrays track the inputs; converter core is off
				next_s.gnd_closed = 1'b1;
				next_s.arr_to_input = 1'b1;
				next_s.powered = 1'b0;
				next_s.step = 4'h0;
				if (cs_fall) begin
					next_s.phase = DSAR_OPEN_GND;
					next_s.powered = 1'b1;
					next_s.code = DSAR_CODE_RESET;
				end
			end
			DSAR_OPEN_GND: begin
				// Ground switches open a full cycle before the arrays move
				next_s.gnd_closed = 1'b0;
				next_s.arr_to_input = 1'b1;
				next_s.powered = 1'b1;
				next_s.phase = DSAR_TO_GND;
			end
			DSAR_TO_GND: begin
				next_s.gnd_closed = 1'b0;
				next_s.arr_to_input = 1'b0;
				next_s.powered = 1'b1;
				next_s.trial = DSAR_MSB_TRIAL;
				next_s.arr.pos_sel = DSAR_MSB_TRIAL;
				next_s.arr.neg_sel = ~DSAR_MSB_TRIAL;
				next_s.step = 4'h0;
				next_s.phase = DSAR_SEARCH;
			end
			DSAR_SEARCH: begin
				next_s.gnd_closed = 1'b0;
				next_s.arr_to_input = 1'b0;
				next_s.powered = 1'b1;
				if (step_end) begin
					next_s.code = next_code;
					next_s.trial = next_trial;
					next_s.step = 4'h0;
					next_s.arr.pos_sel = probe;
					next_s.arr.neg_sel = ~probe;
					// The LSB decision closes the search
					if (last_probe) begin
						next_s.phase = DSAR_FINISH;
					end
				end else begin
					next_s.step = s.step + 4'h1;
				end
			end
			DSAR_FINISH: begin
				next_s.phase = DSAR_ACQUIRE;
				next_s.gnd_closed = 1'b1;
				next_s.arr_to_input = 1'b1;
				next_s.powered = 1'b0;
				next_s.step = 4'h0;
				next_s.done = 1'b1;
			end
			default: begin
				// Unused code: back to tracking with the core off
				next_s.phase = DSAR_ACQUIRE;
				next_s.gnd_closed = 1'b1;
				next_s.arr_to_input = 1'b1;
				next_s.powered = 1'b0;
				next_s.step = 4'h0;
			end
		endcase

		// A search only spans 0000..FFFF offset binary, so both ends clamp
		twos = {~s.code[DSAR_SIGN_POS], s.code[DSAR_SIGN_POS - 1:0]};

		// Falls past the last data bit are not counted
		count_open = sck_fall & (s.fall_cnt != DSAR_FALL_LAST);
		if (count_open) begin
			next_fall = s.fall_cnt + 5'h01;
		end
		at_enable = count_open & (next_fall == DSAR_FALL_OUT_EN);
		in_data = count_open & (next_fall > DSAR_FALL_OUT_EN);
		if (in_data) begin
			bit_idx = 4'(DSAR_FALL_LAST - next_fall);
		end
		// Bits come straight from the running search, decided MSB first
		result_bit = twos[bit_idx];

		// Select high ends the frame and releases the output
		if (cs_high) begin
			next_s.fall_cnt = 5'h00;
			next_s.sout.oe = 1'b0;
			next_s.sout.data = 1'b0;
		end else if (count_open) begin
			next_s.fall_cnt = next_fall;
			if (at_enable) begin
				next_s.sout.oe = 1'b1;
				next_s.sout.data = 1'b0;
			end else if (in_data) begin
				next_s.sout.data = result_bit;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s <= DSAR_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign pos_input_ground_switch = s.gnd_closed;
	assign neg_input_ground_switch = s.gnd_closed;
	assign arrays_to_input = s.arr_to_input;
	assign array_sel = s.arr;
	assign powered_up = s.powered;
	assign conv_done = s.done;
	assign serial_out = s.sout;

endmodule

// ===== verif/dsar_cmp_model.sv
// Comparator model facing the capacitor arrays
module dsar_cmp_model
	import dsar_pkg::*;
(
	input wire dsar_array_s array_sel,
	input wire logic [15:0] offs,
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ns;
	assign comp_above = offs >= array_sel.pos_sel;
endmodule

// ===== verif/dsar_seq_checker.sv
// Port assertions of the conversion sequencer
module dsar_seq_checker
	import dsar_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic pos_input_ground_switch,
	input wire logic neg_input_ground_switch,
	input wire logic arrays_to_input,
	input wire dsar_array_s array_sel,
	input wire logic powered_up,
	input wire logic conv_done,
	input wire dsar_serial_s serial_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_GND_FIRST: assert property ($fell(pos_input_ground_switch) |-> arrays_to_input)
		else $error("arrays left input before grounds opened");
	AST_ARR_GND: assert property ($fell(arrays_to_input) |-> !$past(neg_input_ground_switch))
		else $error("arrays grounded while ground switch closed");
	AST_MSB: assert property ($fell(arrays_to_input) |-> array_sel.pos_sel == 16'h8000)
		else $error("search did not start at msb");
	AST_COMPL: assert property (!arrays_to_input |-> array_sel.neg_sel == ~array_sel.pos_sel)
		else $error("arrays not complementary");
	AST_DONE: assert property (conv_done |-> !powered_up && arrays_to_input ##1 !conv_done)
		else $error("bad state at conversion end");
	AST_SPAN: assert property ($rose(powered_up) |-> ##[45:60] conv_done)
		else $error("conversion length wrong");
	AST_STEP: assert property ($changed(array_sel.pos_sel) |=> $stable(array_sel.pos_sel)[*2])
		else $error("step shorter than three cycles");
	AST_OE: assert property ($rose(serial_out.oe) |-> !serial_out.data)
		else $error("output not low when enabled");
endmodule
bind dsar_seq dsar_seq_checker dsar_seq_checker_inst (.*);

// ===== verif/dsar_seq_tb.sv
// Self-checking bench of the conversion sequencer
module dsar_seq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dsar_pkg::*;
	logic clock = 0, rst = 1, cs_n = 1, serial_shift_clock = 1, comp_above;
	logic pos_input_ground_switch, neg_input_ground_switch, arrays_to_input;
	logic powered_up, conv_done;
	logic [15:0] offs = 0, word;
	dsar_array_s array_sel;
	dsar_serial_s serial_out;
	int error_cnt = 0, num_checks = 0, n = 0, done_cnt = 0;
	int tv[8] = '{0, 1, -1, 32767, 40000, -32768, -40000, -32767};
	logic [15:0] expq[$];
	always #25 clock = ~clock;
	dsar_seq dsar_seq_inst (.*);
	dsar_cmp_model dsar_cmp_model_inst (.*);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One conversion with 22 shift falls, select held low throughout
	task conv(input int v);
		int c;
		int d0;
		c = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
		d0 = done_cnt;
		expq.push_back(16'(c));
		offs <= 16'(c + 32768);
		cs_n <= 0;
		repeat (22) begin
			repeat (4) @(posedge clock);
			serial_shift_clock <= 0;
			repeat (4) @(posedge clock);
			serial_shift_clock <= 1;
		end
		chk(16'(powered_up), 16'h0000);
		chk(16'(done_cnt - d0), 16'h0001);
		cs_n <= 1;
		repeat (8) @(posedge clock);
		chk(16'({serial_out.oe, serial_out.data}), 16'h0000);
	endtask
	always @(negedge clock) if (conv_done) done_cnt++;
	always @(negedge serial_shift_clock or posedge cs_n) begin
		if (cs_n) begin
			n = 0;
		end else begin
			n++;
			if (n == 6) chk(16'({serial_out.oe, serial_out.data}), 16'h0002);
			if (n > 6) word = {word[14:0], serial_out.data};
			if (n == 22) chk(word, expq.pop_front());
		end
	end
	initial begin
		void'($urandom(71));
		repeat (2) @(posedge clock);
		rst <= 0;
		repeat (2) @(posedge clock);
		foreach (tv[i]) conv(tv[i]);
		repeat (4) conv(int'($urandom_range(65535)) - 32768);
		tally_and_finish;
	end
endmodule
